//--- src/boot_irq_ctrl.sv
/*
 * Boot-mode latch, synchronised reset release, external interrupt
 * request conditioning and Wait/Stop wake logic.
 * Assumes the reference clock is the output clock, that the pins are
 * asynchronous to it and that the core acknowledges edge requests.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_irq_ctrl
#(
	parameter int unsigned PHASE_DIV = boot_irq_pkg::PHASE_DIV
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Shared mode/request pins, active low as requests
	input wire logic i_boot_select_a,
	input wire logic i_boot_select_b,
	input wire logic i_boot_select_c,
	input wire logic i_boot_select_d,
	// Interrupt configuration from software
	input wire logic i_cfg_write,
	input wire boot_irq_pkg::irq_cfg_t i_cfg,
	// Core side
	input wire logic [3:0] i_irq_ack,
	input wire logic i_core_wait,
	input wire logic i_core_stop,
	// Outputs to the core
	output logic o_core_reset,
	output logic o_phase_tick,
	output logic [3:0] o_operating_mode,
	output logic [3:0] o_irq_request,
	output logic o_wake_wait,
	output logic o_wake_stop
);
	// Refuse settings the logic cannot serve
	if (PHASE_DIV < 2 || PHASE_DIV > 256)
	begin : g_bad_div
		$error("PHASE_DIV out of range");
	end

	localparam int unsigned PW = $clog2(PHASE_DIV);
	localparam logic [PW-1:0] PHASE_LAST = PW'(PHASE_DIV - 1);

	boot_irq_pkg::seq_state_t state;  // Reset sequencer
	logic [2:0] rst_sync;             // Reset release chain
	logic rst_release;                // Release seen by stages two and three
	logic [3:0] pins;                 // Pins as a vector, bit 0 is pin a
	logic [3:0] pin_s1;               // First stage, read only by stage two
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] filt;                 // Accepted pin level
	logic [3:0] next_filt;
	logic [3:0] fall;                 // Accepted falling edge this cycle
	logic [3:0] edge_pend;            // Sticky edge requests
	logic [3:0] pending;              // Requests before the mask
	boot_irq_pkg::irq_cfg_t cfg;      // Held configuration
	logic [PW-1:0] phase_cnt;         // Phase generator count
	logic run;

	assign pins = {i_boot_select_d, i_boot_select_c, i_boot_select_b, i_boot_select_a};
	assign run = (state == boot_irq_pkg::ST_RUN);
	assign o_core_reset = ~run;

	// Reset chain: asserts at once, releases only on clock edges
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			rst_sync <= 3'h0;
		else
			rst_sync <= {rst_sync[1:0], 1'b1};
	end
	// Stages two and three must agree before release counts
	assign rst_release = rst_sync[1] & rst_sync[2];

	// Sequencer: fixed path so lock-stepped parts start together
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			state <= boot_irq_pkg::ST_RESET;
		else
		begin
			unique case (state)
				// Wait for the synchronised release
				boot_irq_pkg::ST_RESET:
					if (rst_release)
						state <= boot_irq_pkg::ST_LATCH;
				// One cycle to capture the mode code
				boot_irq_pkg::ST_LATCH:
					state <= boot_irq_pkg::ST_RUN;
				// Normal processing
				boot_irq_pkg::ST_RUN:
					state <= boot_irq_pkg::ST_RUN;
				// Two-bit code 2'h2 is unused
				default:
					state <= boot_irq_pkg::ST_RESET;
			endcase
		end
	end

	// Pin synchronisers; no reset so the straps are live at release
	always_ff @(posedge i_ref_clk)
	begin
		pin_s1 <= pins;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	// A level change counts only when stages two and three agree
	always_comb
	begin
		next_filt = filt;
		for (int i = 0; i < 4; i++)
		begin
			if (pin_s2[i] == pin_s3[i])
				next_filt[i] = pin_s3[i];
		end
	end
	assign fall = filt & ~next_filt;

	// Accepted level; idles high meaning no request
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			filt <= 4'hf;
		else
			filt <= next_filt;
	end

	// Mode register: captured once on the release cycle
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_operating_mode <= boot_irq_pkg::MODE_RESET;
		else if (state == boot_irq_pkg::ST_LATCH)
			o_operating_mode <= filt;
	end

	// Configuration: reset leaves every request masked
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cfg.enable <= boot_irq_pkg::CFG_ENABLE_RESET;
			cfg.edge_mode <= boot_irq_pkg::CFG_EDGE_RESET;
		end
		else if (i_cfg_write)
			cfg <= i_cfg;
	end

	// Edge requests are sticky; a new edge beats a same-cycle ack
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			edge_pend <= 4'h0;
		else if (!run)
			edge_pend <= 4'h0;
		else
			edge_pend <= (edge_pend & ~i_irq_ack) | (fall & cfg.edge_mode);
	end

	// Level mode follows the pin; edge mode uses the sticky bit
	assign pending = (cfg.edge_mode & (edge_pend | fall)) | (~cfg.edge_mode & ~filt);

	// Masked requests, only outside reset
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_irq_request <= 4'h0;
		else if (!run)
			o_irq_request <= 4'h0;
		else
			o_irq_request <= cfg.enable & pending;
	end

	// Wait exit: one fixed cycle after a request, so parts resume together
	assign o_wake_wait = i_core_wait & (|o_irq_request);

	// Stop exit on any asserted request pin, mask not consulted
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_wake_stop <= 1'b0;
		else
			o_wake_stop <= run & i_core_stop & (|(~filt));
	end

	// Phase generator held at zero outside normal processing
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			phase_cnt <= '0;
			o_phase_tick <= 1'b0;
		end
		else if (!run)
		begin
			phase_cnt <= '0;
			o_phase_tick <= 1'b0;
		end
		else
		begin
			o_phase_tick <= (phase_cnt == PHASE_LAST);
			phase_cnt <= (phase_cnt == PHASE_LAST) ? '0 : phase_cnt + 1'b1;
		end
	end

	// Checks
	a_mode_capture: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		state == boot_irq_pkg::ST_LATCH |=> o_operating_mode == $past(filt))
		else $error("mode code not captured at release");
	a_mode_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		run && $past(run) |-> $stable(o_operating_mode))
		else $error("mode register changed while running");
	a_reset_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!$past(run) |-> o_irq_request == 4'h0)
		else $error("request seen during reset");
	a_mask_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(o_irq_request & ~$past(cfg.enable)) == 4'h0)
		else $error("masked request passed");
	a_edge_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		run && |(edge_pend & ~i_irq_ack) |=>
		(($past(edge_pend) & ~$past(i_irq_ack)) & ~edge_pend) == 4'h0)
		else $error("edge request lost without ack");
	a_sync_accept: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		pin_s2 == pin_s3 |=> filt == $past(pin_s3))
		else $error("agreed pin level not accepted");
	a_wait_exit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		run && |(cfg.enable & ~cfg.edge_mode & ~filt) && !i_cfg_write ##1 i_core_wait
		|-> o_wake_wait)
		else $error("wait not ended one cycle after request");
	a_stop_exit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		run && i_core_stop && filt != 4'hf |=> o_wake_stop)
		else $error("stop not left on request");
	a_release_path: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		$rose(rst_release) |-> state == boot_irq_pkg::ST_RESET ##1
		state == boot_irq_pkg::ST_LATCH ##1 run)
		else $error("start-up not on fixed path");
	a_phase_reset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!run |-> phase_cnt == '0 ##1 (!o_phase_tick || $past(run)))
		else $error("phase generator ran in reset");
endmodule // boot_irq_ctrl
`default_nettype wire

//--- src/boot_irq_pkg.sv
/*
 * Shared constants and types for the boot-mode latch and external
 * interrupt block.
 * Assumes a single reference clock that is also the output clock.
 */
`default_nettype none
package boot_irq_pkg;
	// Number of shared mode/request pins
	localparam int unsigned NUM_PINS = 4;
	// Width of the captured start-up mode code
	localparam int unsigned MODE_WIDTH = 4;
	// Mode register value while in reset
	localparam logic [3:0] MODE_RESET = 4'h0;
	// Reset values of the configuration bits: all masked, all level
	localparam logic [3:0] CFG_ENABLE_RESET = 4'h0;
	localparam logic [3:0] CFG_EDGE_RESET = 4'h0;
	// Depth of the pin and reset synchronisers
	localparam int unsigned SYNC_STAGES = 3;
	// Reference clock rate and period
	localparam int unsigned REF_CLK_HZ = 50_000_000;
	localparam int unsigned REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
	// Phase generator: clocks per phase tick
	localparam int unsigned PHASE_DIV = 4;
	// Field positions inside the configuration word
	localparam int unsigned CFG_ENABLE_LSB = 4;
	localparam int unsigned CFG_EDGE_LSB = 0;

	// Reset sequencer states, Gray coded along the path
	typedef enum logic [1:0]
	{
		ST_RESET = 2'h0,
		ST_LATCH = 2'h1,
		ST_RUN = 2'h3
	} seq_state_t;

	// Per-pin interrupt configuration written by software
	typedef struct packed
	{
		logic [3:0] enable;     // 1 = request passed on
		logic [3:0] edge_mode;  // 1 = falling edge, 0 = low level
	} irq_cfg_t;
endpackage
`default_nettype wire

//--- src/unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- tb/boot_board.sv
/*
 * Board model: mode straps, request sources and the reset source.
 * Assumes the bench steers its controls at falling clock edges.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_board
(
	// Clock and bench controls
	input wire logic i_ref_clk,
	input wire logic i_hold_reset,
	input wire logic [3:0] i_strap,
	input wire logic [3:0] i_req_n,
	// Pins towards the device
	output logic o_resetn,
	output logic [3:0] o_pins
);
	int hold_cnt = 0; // Cycles the straps still stand after release
	// Reset tracks a level driven off the falling edge, so release is clock-aligned
	assign o_resetn = ~i_hold_reset;
	// Straps outlive release: the capture sees pins a few flops late
	always @(negedge i_ref_clk)
		hold_cnt <= i_hold_reset ? 6 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
	// Idle request lines sit at the pull-up level
	assign o_pins = (i_hold_reset || hold_cnt > 0) ? i_strap : i_req_n;
endmodule // boot_board
`default_nettype wire

//--- tb/boot_irq_ctrl_bench.sv
/*
 * Self-checking bench for the boot latch and request block.
 * Assumes the board model drives reset and pins; outputs compared by queue.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_irq_ctrl_bench;
	localparam int PD = 3; // Shortened phase divider
	typedef struct packed { logic [11:0] v; logic [11:0] m; } note_t;
	logic i_ref_clk = 1'b0; // Reference clock
	logic hold = 1'b1, cfg_write = 1'b0, core_wait = 1'b0, core_stop = 1'b0;
	logic [3:0] strap = 4'h0, req_n = 4'hf, ack = 4'h0, sel = 4'h1;
	logic [3:0] pins, mode, req;
	logic resetn, core_reset, phase_tick, wake_wait, wake_stop;
	boot_irq_pkg::irq_cfg_t cfg = '0;
	note_t notes[$]; // Expected results, oldest first
	note_t n;
	int fails = 0, n_tests = 0;
	logic [31:0] seed = 32'h00011d7d;
	wire logic [11:0] obs = {phase_tick, core_reset, mode, req, wake_wait, wake_stop};
	always #10 i_ref_clk = ~i_ref_clk;
	boot_board i_board (.i_ref_clk(i_ref_clk), .i_hold_reset(hold), .i_strap(strap),
		.i_req_n(req_n), .o_resetn(resetn), .o_pins(pins));
	boot_irq_ctrl #(.PHASE_DIV(PD)) i_dut (.i_ref_clk(i_ref_clk), .i_resetn(resetn),
		.i_boot_select_a(pins[0]), .i_boot_select_b(pins[1]), .i_boot_select_c(pins[2]),
		.i_boot_select_d(pins[3]), .i_cfg_write(cfg_write), .i_cfg(cfg), .i_irq_ack(ack),
		.i_core_wait(core_wait), .i_core_stop(core_stop), .o_core_reset(core_reset),
		.o_phase_tick(phase_tick), .o_operating_mode(mode), .o_irq_request(req),
		.o_wake_wait(wake_wait), .o_wake_stop(wake_stop));
	task automatic tick(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask
	// Note what the outputs must show at this falling edge
	task automatic chk(input logic [11:0] v, input logic [11:0] m);
		notes.push_back(note_t'{v, m});
	endtask
	// One-cycle configuration strobe
	task automatic wcfg(input logic [3:0] en, input logic [3:0] ed);
		cfg = '{en, ed};
		cfg_write = 1'b1;
		tick(1);
		cfg_write = 1'b0;
	endtask
	function automatic void nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watcher: after inputs land, compare every pending note
	always @(negedge i_ref_clk)
	begin
		#1;
		while (notes.size() > 0)
		begin
			n = notes.pop_front();
			n_tests++;
			if ((obs & n.m) !== (n.v & n.m))
			begin
				fails++;
				$display("BAD %0t got %h want %h", $time, obs & n.m, n.v & n.m);
			end
		end
	end
	// Watchdog sized well past the expected run
	initial
	begin
		#5000;
		fails++;
		final_report();
	end
	initial
	begin
		nxt();
		strap = seed[3:0];
		sel = 4'h1 << seed[5:4];
		tick(5);
		chk(12'h400, 12'hfff);
		tick(5);
		hold = 1'b0;
		// Release counts at the third edge, run begins at the fifth
		tick(4);
		chk(12'h400, 12'h400);
		tick(1);
		chk({2'h0, strap, 6'h00}, 12'h7c0);
		tick(PD - 1);
		chk(12'h000, 12'h800);
		tick(1);
		chk(12'h800, 12'h800);
		tick(10);
		req_n = ~sel;
		tick(6);
		chk(12'h000, 12'h03c);
		core_stop = 1'b1;
		tick(2);
		chk(12'h001, 12'h001);
		core_stop = 1'b0;
		wcfg(4'hf, 4'h0);
		core_wait = 1'b1;
		tick(2);
		chk({6'h00, sel, 2'h2}, 12'h03e);
		wcfg(~sel, 4'h0);
		tick(2);
		chk(12'h000, 12'h03e);
		// Wait stays up past the compare, else the wake output is not really looked at
		tick(1);
		req_n = 4'hf;
		core_wait = 1'b0;
		wcfg(4'hf, 4'hf);
		tick(8);
		req_n = ~sel;
		tick(4);
		req_n = 4'hf;
		tick(6);
		chk({6'h00, sel, 2'h0}, 12'h03c);
		ack = sel;
		tick(1);
		ack = 4'h0;
		tick(2);
		chk(12'h000, 12'h03c);
		// Mid-run reset with a fresh strap: start-up must repeat cycle for cycle
		hold = 1'b1;
		nxt();
		strap = seed[3:0];
		tick(2);
		chk(12'h400, 12'hfff);
		tick(3);
		hold = 1'b0;
		tick(4);
		chk(12'h400, 12'h400);
		tick(1);
		chk({2'h0, strap, 6'h00}, 12'h7c0);
		tick(PD - 1);
		chk(12'h000, 12'h800);
		tick(1);
		chk(12'h800, 12'h800);
		tick(2);
		final_report();
	end
endmodule // boot_irq_ctrl_bench
`default_nettype wire
